// ===== design/csp_core.sv
// Filter core stream ends: input sink, decimating sum, output source
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_core
    import csp_pkg::*;
#(
    parameter int DATA_W = `CSP_DATA_W,
    parameter int SYMBOLS = `CSP_SYMBOLS,
    parameter int CHANNELS = `CSP_CHANNELS,
    parameter int RATE_LIMIT = `CSP_RATE_LIMIT,
    parameter bit VAR_RATE = 1'b1,
    parameter int FIXED_RATE = `CSP_RATE_RESET,
    parameter int DEPTH = `CSP_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    csp_stream_if.dev port,
    output logic [DATA_W*SYMBOLS-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic out_sop,
    output logic out_eop,
    output logic [$clog2(CHANNELS)-1:0] out_channel
);
    localparam int CH_W = $clog2(CHANNELS);
    localparam int RATE_W = $clog2(RATE_LIMIT);
    localparam int W = DATA_W * SYMBOLS;
    localparam int CNT_W = RATE_W + 1;
    initial begin
        if (CHANNELS < 2)
            $error("At least two channels are needed");
        if (RATE_LIMIT < 2)
            $error("Rate limit must be at least two");
        if (SYMBOLS < 1)
            $error("A beat needs at least one symbol");
        // Counter has a spare bit, so the limit itself still fits
        if (!VAR_RATE && (FIXED_RATE < 1 || FIXED_RATE > RATE_LIMIT))
            $error("Fixed rate outside the supported range");
        if ($bits(port.rate) != RATE_W)
            $error("Rate input width must match the rate limit");
        if ($bits(port.in_data) != W)
            $error("Beat width must be symbols times data width");
        if (`CSP_READY_DELAY != 0)
            $error("Only zero ready delay is supported");
    end

    function automatic logic [W-1:0] lane_add(
        input logic [W-1:0] a,
        input logic [W-1:0] b
    );
        logic [W-1:0] r;
        r = '0;
        // Symbols added lane by lane, wrapping per lane
        for (int i = 0; i < SYMBOLS; i++)
            r[i*DATA_W +: DATA_W] = a[i*DATA_W +: DATA_W] +
                b[i*DATA_W +: DATA_W];
        return r;
    endfunction : lane_add

    // One decode of the last channel, so both group ends agree
    function automatic logic last_ch(input logic [CH_W-1:0] ch);
        return ch == CH_W'(CHANNELS - 1);
    endfunction : last_ch

    csp_state_t state_reg;
    logic [W-1:0] acc_reg [CHANNELS];
    logic [CH_W-1:0] in_ch_reg;
    logic [CH_W-1:0] emit_ch_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] rate_eff;
    logic [CNT_W-1:0] rate_reg;
    logic in_take;
    logic last_in;
    logic [W-1:0] f_wr_data;
    logic f_wr_valid;
    logic f_wr_ready;
    logic [W+CH_W-1:0] f_rd_data;
    logic [W+CH_W-1:0] f_wr_word;

    // Zero rate is treated as one: pass-through
    always_comb begin
        if (VAR_RATE)
            rate_eff = (port.rate == '0) ? CNT_W'(1) :
                CNT_W'(port.rate);
        else
            rate_eff = CNT_W'(FIXED_RATE);
    end

    // Input refused while draining sums into the FIFO
    assign port.in_ready = (state_reg != CSP_EMIT);
    assign in_take = port.in_valid && port.in_ready;
    assign last_in = port.in_eop ||
        last_ch(in_ch_reg);

    always_ff @(posedge sys_clk) begin
        if (rst)
            in_ch_reg <= '0;
        else if (in_take)
            in_ch_reg <= last_in ? '0 : in_ch_reg + 1'b1;
        else if (port.in_valid && port.in_sop)
            in_ch_reg <= '0;
    end

    // Rate sampled once per decimation period to keep periods whole
    always_ff @(posedge sys_clk) begin
        if (rst)
            rate_reg <= CNT_W'(1);
        else if (state_reg == CSP_IDLE)
            rate_reg <= rate_eff;
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            state_reg <= CSP_IDLE;
        else begin
            unique case (state_reg)
                CSP_IDLE: begin
                    if (in_take && last_in)
                        state_reg <= (rate_eff == CNT_W'(1)) ?
                            CSP_EMIT : CSP_ACC;
                    else if (in_take)
                        state_reg <= CSP_ACC;
                end
                CSP_ACC: begin
                    if (in_take && last_in &&
                        cnt_reg == rate_reg - 1'b1)
                        state_reg <= CSP_EMIT;
                end
                // Leaves once the last channel's sum is buffered
                CSP_EMIT: begin
                    if (f_wr_ready &&
                        last_ch(emit_ch_reg))
                        state_reg <= CSP_IDLE;
                end
                default: state_reg <= CSP_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            cnt_reg <= '0;
        else if (state_reg == CSP_EMIT)
            cnt_reg <= '0;
        else if (in_take && last_in)
            cnt_reg <= cnt_reg + 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int c = 0; c < CHANNELS; c++)
                acc_reg[c] <= '0;
        end else if (in_take) begin
            if (state_reg == CSP_IDLE || cnt_reg == '0)
                acc_reg[in_ch_reg] <= port.in_data;
            else
                acc_reg[in_ch_reg] <= lane_add(acc_reg[in_ch_reg],
                    port.in_data);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            emit_ch_reg <= '0;
        else if (state_reg == CSP_EMIT && f_wr_ready)
            emit_ch_reg <= last_ch(emit_ch_reg) ?
                '0 : emit_ch_reg + 1'b1;
    end

    // FIFO back-pressure stalls emission, then input
    assign f_wr_valid = (state_reg == CSP_EMIT);
    assign f_wr_data = acc_reg[emit_ch_reg];
    // Channel travels with its sum, so output flags cannot slip
    assign f_wr_word = {emit_ch_reg, f_wr_data};

    csp_fifo #(
        .WIDTH(W + CH_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_data(f_wr_word),
        .wr_valid(f_wr_valid),
        .wr_ready(f_wr_ready),
        .rd_data(f_rd_data),
        .rd_valid(out_valid),
        .rd_ready(out_ready)
    );

    assign out_data = f_rd_data[W-1:0];
    assign out_channel = f_rd_data[W+CH_W-1:W];
    assign out_sop = out_valid && out_channel == '0;
    assign out_eop = out_valid &&
        last_ch(out_channel);
endmodule : csp_core

// ===== design/csp_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module csp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [WIDTH-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("FIFO depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;
    assign wr_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
    assign rd_valid = wr_ptr_reg != rd_ptr_reg;
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;
    assign rd_data = mem[rd_ptr_reg[AW-1:0]];
    always_ff @(posedge sys_clk) begin
        if (push)
            mem[wr_ptr_reg[AW-1:0]] <= wr_data;
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            wr_ptr_reg <= '0;
        else if (push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            rd_ptr_reg <= '0;
        else if (pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
endmodule : csp_fifo

// ===== design/csp_source.sv
// Upstream sample source end: feeds packets of channel samples
`timescale 1ns/1ps
`include "csp_regs.svh"
module csp_source #(
    parameter int DATA_W = `CSP_DATA_W,
    parameter int SYMBOLS = `CSP_SYMBOLS,
    parameter int CHANNELS = `CSP_CHANNELS,
    parameter int RATE_LIMIT = `CSP_RATE_LIMIT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [DATA_W*SYMBOLS-1:0] user_data,
    input wire logic user_valid,
    output logic user_ready,
    input wire logic [$clog2(RATE_LIMIT)-1:0] user_rate,
    csp_stream_if.src port
);
    localparam int CH_W = $clog2(CHANNELS);
    logic [CH_W-1:0] ch_reg;
    logic [$clog2(RATE_LIMIT)-1:0] rate_reg;
    logic [DATA_W*SYMBOLS-1:0] data_reg;
    logic valid_reg;
    logic take;
    // Holding register frees the slot only on a taken beat
    assign user_ready = !valid_reg || port.in_ready;
    assign take = valid_reg && port.in_ready;
    assign port.in_data = data_reg;
    assign port.in_valid = valid_reg;
    assign port.in_sop = valid_reg && ch_reg == '0;
    assign port.in_eop = valid_reg &&
        ch_reg == CH_W'(CHANNELS - 1);
    assign port.rate = rate_reg;
    always_ff @(posedge sys_clk) begin
        if (rst)
            valid_reg <= 1'b0;
        else if (user_ready)
            valid_reg <= user_valid;
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            data_reg <= '0;
        else if (user_ready && user_valid)
            data_reg <= user_data;
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            ch_reg <= '0;
        else if (take)
            ch_reg <= (ch_reg == CH_W'(CHANNELS - 1)) ? '0 : ch_reg + 1'b1;
    end
    always_ff @(posedge sys_clk) begin
        if (rst)
            rate_reg <= ($clog2(RATE_LIMIT))'(`CSP_RATE_RESET);
        else
            rate_reg <= user_rate;
    end
endmodule : csp_source

// ===== pkg/csp_pkg.sv
// State type used only by the filter core
package csp_pkg;
    typedef enum logic [2:0] {
        CSP_IDLE = 3'b001,
        CSP_ACC = 3'b010,
        CSP_EMIT = 3'b100
    } csp_state_t;
endpackage : csp_pkg

// ===== pkg/csp_regs.svh
// Constants for the filter stream port handshake
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
`define CSP_DATA_W 16
`define CSP_CHANNELS 4
`define CSP_SYMBOLS 1
`define CSP_RATE_LIMIT 16
`define CSP_RATE_RESET 4
`define CSP_FIFO_DEPTH 8
`define CSP_READY_DELAY 0
`endif

// ===== pkg/csp_stream_if.sv
// Stream interface between sample source and filter core
`timescale 1ns/1ps
`include "csp_regs.svh"
interface csp_stream_if #(
    parameter int DATA_W = `CSP_DATA_W,
    parameter int SYMBOLS = `CSP_SYMBOLS,
    parameter int CH_W = $clog2(`CSP_CHANNELS),
    parameter int RATE_W = $clog2(`CSP_RATE_LIMIT)
);
    logic [DATA_W*SYMBOLS-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic in_sop;
    logic in_eop;
    logic [RATE_W-1:0] rate;
    modport dev (
        input in_data, in_valid, in_sop, in_eop, rate,
        output in_ready
    );
    modport src (
        output in_data, in_valid, in_sop, in_eop, rate,
        input in_ready
    );
endinterface : csp_stream_if

// ===== test/csp_stream_sva.sv
// Checker on the stream interface between source end and core
`timescale 1ns/1ps
module csp_stream_sva #(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] in_data,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic in_sop,
    input wire logic in_eop,
    input wire logic [3:0] rate
);
    logic [7:0] ch_reg;
    logic xfer;
    assign xfer = in_valid && in_ready;
    // Own beat count, so flags are judged against accepted beats only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ch_reg <= 8'h00;
        end else if (xfer) begin
            ch_reg <= in_eop ? 8'h00 : ch_reg + 8'h01;
        end
    end
    // Packets per refusal period, against the rate seen at its start
    logic [4:0] pk_cnt_reg;
    logic [3:0] per_rate_reg;
    logic open_reg;
    always_ff @(posedge sys_clk) begin
        if (rst || !in_ready) begin
            open_reg <= 1'b0;
            pk_cnt_reg <= 5'h00;
        end else if (xfer) begin
            open_reg <= 1'b1;
            if (!open_reg)
                per_rate_reg <= (rate == 4'h0) ? 4'h1 : rate;
            if (in_eop)
                pk_cnt_reg <= pk_cnt_reg + 5'h01;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_hold;
        in_valid && !in_ready |=> in_valid && $stable(in_data)
            && $stable(in_sop) && $stable(in_eop);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stalled beat changed");
    property p_sop_first;
        xfer && ch_reg == 8'h00 |-> in_sop;
    endproperty
    a_sop_first: assert property (p_sop_first)
        else $error("first beat lacks start flag");
    property p_eop_last;
        xfer && ch_reg == 8'(CHANNELS - 1) |-> in_eop;
    endproperty
    a_eop_last: assert property (p_eop_last)
        else $error("last beat lacks end flag");
    property p_sop_only;
        xfer && in_sop |-> ch_reg == 8'h00;
    endproperty
    a_sop_only: assert property (p_sop_only)
        else $error("start flag in mid packet");
    property p_eop_only;
        xfer && in_eop |-> ch_reg == 8'(CHANNELS - 1);
    endproperty
    a_eop_only: assert property (p_eop_only)
        else $error("end flag in mid packet");
    property p_rate_width;
        $fell(in_ready) |-> pk_cnt_reg == {1'b0, per_rate_reg};
    endproperty
    a_rate_width: assert property (p_rate_width)
        else $error("period length does not follow the rate input");
    property p_reset_state;
        $fell(rst) |-> !in_valid && in_ready && rate == 4'h4;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("port not idle after reset");
    property p_refuse_span;
        $fell(in_ready) |-> !in_ready [*4];
    endproperty
    a_refuse_span: assert property (p_refuse_span)
        else $error("refusal shorter than one result group");
endmodule : csp_stream_sva

// ===== test/tb_cic_stream_port_handshake.sv
// Bench for source end, stream interface and core together
`timescale 1ns/1ps
module tb_cic_stream_port_handshake;
    typedef struct {
        logic [3:0] rt;
        logic [15:0] base;
        logic [15:0] e0;
    } csp_row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] user_data = 16'h0000;
    logic user_valid = 1'b0;
    logic user_ready;
    logic [3:0] user_rate = 4'h4;
    logic [15:0] out_data;
    logic out_valid;
    logic out_ready = 1'b1;
    logic out_sop;
    logic out_eop;
    logic [1:0] out_channel;
    logic [19:0] got_q[$];
    logic stall_reg = 1'b0;
    logic [15:0] held_reg = 16'h0000;
    int n_fail = 0;
    int n_tests = 0;
    // Rate 0 acts as 1; rate 15 exercises the widest count and wrap
    csp_row_t rows[4] = '{'{4'h1, 16'h0100, 16'h0100},
        '{4'h2, 16'h1000, 16'h2001}, '{4'h0, 16'h00A5, 16'h00A5},
        '{4'hF, 16'hF000, 16'h1069}};
    csp_stream_if bus ();
    csp_source i_csp_source (.sys_clk(sys_clk), .rst(rst),
        .user_data(user_data), .user_valid(user_valid),
        .user_ready(user_ready), .user_rate(user_rate), .port(bus));
    csp_core i_csp_core (.sys_clk(sys_clk), .rst(rst), .port(bus),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_sop(out_sop), .out_eop(out_eop), .out_channel(out_channel));
    csp_stream_sva i_csp_stream_sva (.sys_clk(sys_clk), .rst(rst),
        .in_data(bus.in_data), .in_valid(bus.in_valid),
        .in_ready(bus.in_ready), .in_sop(bus.in_sop), .in_eop(bus.in_eop),
        .rate(bus.rate));
    always #5 sys_clk = ~sys_clk;
    task automatic chk_word(input string s, input logic [15:0] e,
        input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string s, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", s, e, g);
        end
    endtask : chk_bit
    always @(posedge sys_clk) begin
        if (stall_reg) begin
            chk_bit("out_valid held", 1'b1, out_valid);
            chk_word("out_data held", held_reg, out_data);
        end
        stall_reg = !rst && out_valid === 1'b1 && !out_ready;
        held_reg = out_data;
        if (!rst && out_valid === 1'b1 && out_ready) begin
            got_q.push_back({out_channel, out_sop, out_eop, out_data});
        end
    end
    task automatic send(input logic [15:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        user_data = d;
        user_valid = 1'b1;
        // Ready is settled mid-cycle; the beat lands at the next rise
        while (user_ready !== 1'b1 && n < 500) begin
            n++;
            @(negedge sys_clk);
        end
        if (n >= 500)
            n_fail++;
        @(posedge sys_clk);
    endtask : send
    task automatic feed(input logic [3:0] rt, input logic [15:0] b,
        input int pk);
        @(negedge sys_clk);
        user_rate = rt;
        repeat (3) @(posedge sys_clk);
        for (int p = 0; p < pk; p++) begin
            for (int c = 0; c < 4; c++) begin
                send(b + 16'(16 * c + p));
            end
        end
        @(negedge sys_clk);
        user_valid = 1'b0;
    endtask : feed
    task automatic expect_group(input logic [15:0] e0, input int r);
        logic [19:0] w;
        int n;
        for (int c = 0; c < 4; c++) begin
            n = 0;
            while (got_q.size() == 0 && n < 500) begin
                n++;
                @(posedge sys_clk);
            end
            w = (got_q.size() > 0) ? got_q.pop_front() : 20'hFFFFF;
            chk_word("out_data", e0 + 16'(16 * c * r), w[15:0]);
            chk_word("out_channel", 16'(c), {14'h0000, w[19:18]});
            chk_bit("out_sop", c == 0, w[17]);
            chk_bit("out_eop", c == 3, w[16]);
        end
    endtask : expect_group
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        chk_bit("out_valid reset", 1'b0, out_valid);
        foreach (rows[i]) begin
            feed(rows[i].rt, rows[i].base,
                (rows[i].rt == 4'h0) ? 1 : rows[i].rt);
            expect_group(rows[i].e0, (rows[i].rt == 4'h0) ? 1 : rows[i].rt);
        end
        // Output stalled: buffer of 8 fills, core must refuse input
        @(negedge sys_clk);
        out_ready = 1'b0;
        fork
            feed(4'h1, 16'h0200, 3);
            begin
                repeat (80) @(negedge sys_clk);
                chk_bit("in_ready full", 1'b0, bus.in_ready);
                out_ready = 1'b1;
            end
        join
        for (int p = 0; p < 3; p++) begin
            expect_group(16'h0200 + 16'(p), 1);
        end
        send(16'h0AAA);
        send(16'h0BBB);
        @(negedge sys_clk);
        user_valid = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        feed(4'h1, 16'h0100, 1);
        expect_group(16'h0100, 1);
        repeat (10) @(posedge sys_clk);
        chk_bit("out_valid empty", 1'b0, out_valid);
        chk_word("extra results", 16'h0000, 16'(got_q.size()));
        complete_run();
    end
endmodule : tb_cic_stream_port_handshake
